// *** verilog/hdsp_pkg.sv ***
// Package for the Hall signal-conditioning configuration and diagnosis block.
// Assumes a single 50 MHz system clock and a synchronous active-high reset.
package hdsp_pkg;
  localparam int CLK_HZ = 50000000;
  // Register indices on the programming port
  localparam logic [5:0] A_STATUS = 6'h00;
  localparam logic [5:0] A_PROGERR = 6'h01;
  localparam logic [5:0] A_TAG1 = 6'h02;
  localparam logic [5:0] A_TAG2 = 6'h03;
  localparam logic [5:0] A_TGC0 = 6'h04;
  localparam logic [5:0] A_TGC1 = 6'h05;
  localparam logic [5:0] A_TGC2 = 6'h06;
  localparam logic [5:0] A_TOC0 = 6'h07;
  localparam logic [5:0] A_TOC1 = 6'h08;
  localparam logic [5:0] A_PLGAIN = 6'h09;
  localparam logic [5:0] A_PLOFF = 6'h0a;
  localparam logic [5:0] A_OGAIN = 6'h0b;
  localparam logic [5:0] A_OOFF = 6'h0c;
  localparam logic [5:0] A_CLHI = 6'h0d;
  localparam logic [5:0] A_CLLO = 6'h0e;
  localparam logic [5:0] A_SETUP = 6'h0f;
  localparam logic [5:0] A_LINPT = 6'h10;
  localparam logic [5:0] A_RAWFLD = 6'h20;
  localparam logic [5:0] A_OUTVAL = 6'h21;
  // Status and error bit positions
  localparam int B_FSM_FAIL = 5;
  localparam int B_MEM_FAIL = 4;
  localparam int B_ROM_FAIL = 3;
  localparam int B_ADC_OVF = 2;
  localparam int B_PUMP_ERR = 10;
  localparam int B_SUPPLY_ERR = 9;
  localparam int B_NVM_ERR = 8;
  // Setup word fields
  localparam int SETUP_LOCK = 0;
  localparam int RANGE_LSB = 12;
  localparam int RATE_LSB = 10;
  localparam logic [15:0] SETUP_MASK_PWM = 16'h7fff;
  localparam logic [15:0] SETUP_MASK_ANA = 16'h73ff;
  localparam logic [15:0] STATUS_MASK = 16'h003c;
  localparam logic [15:0] PROGERR_MASK = 16'h0700;
  // Values after reset
  localparam logic [15:0] RST_UNITY = 16'h7fff;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_CLHI = 16'h7fff;
  localparam logic [15:0] RST_SETUP = 16'h1000;
  // Signal path
  localparam int RAW_W = 22;
  localparam int SAMPLE_W = 39;
  localparam int FIFO_DEPTH = 32;
  localparam logic [2:0] RANGE_MAX = 3'h6;
  localparam int Q_SHIFT = 15;
  localparam int SEG_SHIFT = 11;
  localparam int NUM_PTS = 16;
  // Pulse rate select
  localparam int F_2K_HZ = 2000;
  localparam int F_1K_HZ = 1000;
  localparam int F_500_HZ = 500;
  localparam int F_250_HZ = 250;
  localparam logic [17:0] PER_2K = 18'(CLK_HZ / F_2K_HZ);
  localparam logic [17:0] PER_1K = 18'(CLK_HZ / F_1K_HZ);
  localparam logic [17:0] PER_500 = 18'(CLK_HZ / F_500_HZ);
  localparam logic [17:0] PER_250 = 18'(CLK_HZ / F_250_HZ);
  localparam logic [3:0] RES_11 = 4'hb;
  localparam logic [3:0] RES_12 = 4'hc;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_RANGE = 6'b000010,
    ST_TEMP = 6'b000100,
    ST_PRELIN = 6'b001000,
    ST_LIN = 6'b010000,
    ST_OUT = 6'b100000
  } hdsp_state_t;
endpackage : hdsp_pkg

// *** verilog/hdsp_fifo.sv ***
// Sample FIFO with valid/ready on both sides.
// Assumes both sides run on sys_clk.
`timescale 1ns/1ns
`default_nettype none
module hdsp_fifo #(
  parameter int WIDTH = 39,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic ready_reg;
  logic push;
  logic pop;
  assign push = in_valid && ready_reg;
  assign pop = out_valid && out_ready;
  assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
  // Ready kept in its own flop so the pin has no gate after it
  assign in_ready = ready_reg;
  assign out_valid = count_reg != '0;
  assign out_data = mem[rd_ptr_reg];
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b1;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + AW'(push);
      rd_ptr_reg <= rd_ptr_reg + AW'(pop);
      count_reg <= count_next;
      ready_reg <= count_next != (AW+1)'(DEPTH);
    end
  end
endmodule : hdsp_fifo
`default_nettype wire

// *** verilog/hdsp_core.sv ***
// Signal conditioning path, configuration registers and diagnosis flags.
// Assumes fault inputs come from logic on sys_clk; the register port is
// driven by a same-clock decoder of the output-pin programming protocol.
`timescale 1ns/1ns
`default_nettype none
module hdsp_core #(
  parameter bit PULSE_VARIANT = 1'b1
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic [hdsp_pkg::RAW_W-1:0] sample_raw,
  input wire logic [15:0] sample_temp,
  input wire logic sample_overrange,
  output logic out_valid,
  input wire logic out_ready,
  output logic [15:0] out_value,
  output logic [17:0] pulse_period,
  output logic [3:0] pulse_resolution,
  output logic memory_locked,
  input wire logic fsm_selftest_fail,
  input wire logic powerup_check,
  input wire logic mem_selftest_fail,
  input wire logic rom_parity_fail,
  input wire logic prog_start,
  input wire logic pump_low,
  input wire logic supply_low,
  input wire logic nvm_prog_fail,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid
);
  import hdsp_pkg::*;

  function automatic logic signed [47:0] sx16(input logic [15:0] v);
    return {{32{v[15]}}, v};
  endfunction : sx16

  // Wide product keeps polynomial terms exact before the shift
  function automatic logic signed [47:0] mul_sh(input logic signed [47:0] a, input logic signed [47:0] b,
                                                input int sh);
    logic signed [95:0] p;
    p = a * b;
    return 48'(p >>> sh);
  endfunction : mul_sh

  function automatic logic [15:0] sat16(input logic signed [47:0] v);
    if (v > 48'sd32767) begin
      return 16'h7fff;
    end else if (v < -48'sd32768) begin
      return 16'h8000;
    end
    return v[15:0];
  endfunction : sat16

  logic [15:0] status_reg;
  logic [15:0] progerr_reg;
  logic [15:0] tag1_reg;
  logic [15:0] tag2_reg;
  logic [15:0] tgc0_reg;
  logic [15:0] tgc1_reg;
  logic [15:0] tgc2_reg;
  logic [15:0] toc0_reg;
  logic [15:0] toc1_reg;
  logic [15:0] plgain_reg;
  logic [15:0] ploff_reg;
  logic [15:0] ogain_reg;
  logic [15:0] ooff_reg;
  logic [15:0] clhi_reg;
  logic [15:0] cllo_reg;
  logic [15:0] setup_reg;
  logic [15:0] lin_pts [NUM_PTS];
  logic lock_reg;
  logic [15:0] raw_field_value;
  logic [15:0] field_comp_reg;
  logic [15:0] lin_in_reg;
  logic [15:0] lin_out_reg;
  logic [15:0] temp_reg;
  logic [RAW_W-1:0] raw_reg;
  logic ovf_seen_reg;
  logic [15:0] out_value_reg;
  logic out_valid_reg;
  hdsp_state_t state_reg;
  hdsp_state_t state_next;

  // Sample FIFO
  logic fifo_valid;
  logic fifo_take;
  logic [SAMPLE_W-1:0] fifo_data;
  assign fifo_take = state_reg == ST_IDLE;
  hdsp_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .srst(srst),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .in_data({sample_overrange, sample_temp, sample_raw}),
    .out_valid(fifo_valid),
    .out_ready(fifo_take),
    .out_data(fifo_data)
  );

  // Register port decode
  wire wr_ok = reg_wr && !lock_reg;
  wire wr_setup = wr_ok && reg_addr == A_SETUP;
  wire wr_pt = wr_ok && reg_addr[5:4] == A_LINPT[5:4];
  wire [15:0] setup_mask = PULSE_VARIANT ? SETUP_MASK_PWM : SETUP_MASK_ANA;

  // Range shifter: code 7 treated as the narrowest range
  wire [2:0] range_code = setup_reg[RANGE_LSB+2:RANGE_LSB] > RANGE_MAX ? RANGE_MAX :
                          setup_reg[RANGE_LSB+2:RANGE_LSB];
  // Higher codes drop more top bits; all of them must repeat the sign
  wire [RAW_W-1:0] raw_aligned = raw_reg << range_code;
  wire [RAW_W-1:0] raw_back = $signed(raw_aligned) >>> range_code;
  wire raw_fits = raw_back == raw_reg;
  assign raw_field_value = raw_fits ? raw_aligned[RAW_W-1:RAW_W-16] :
                           (raw_reg[RAW_W-1] ? 16'h8000 : 16'h7fff);

  // Temperature gain and offset
  wire signed [47:0] t_sx = sx16(temp_reg);
  wire signed [47:0] t_sq = mul_sh(t_sx, t_sx, Q_SHIFT);
  wire signed [47:0] gain_poly = sx16(tgc0_reg) + mul_sh(sx16(tgc1_reg), t_sx, Q_SHIFT) +
                                 mul_sh(sx16(tgc2_reg), t_sq, Q_SHIFT);
  wire signed [47:0] off_poly = sx16(toc0_reg) + mul_sh(sx16(toc1_reg), t_sx, Q_SHIFT);
  wire [15:0] temp_result = sat16(mul_sh(sx16(raw_field_value), gain_poly, Q_SHIFT) + off_poly);

  // Prescale into the linearizer range
  wire signed [47:0] pre_sum = mul_sh(sx16(field_comp_reg), sx16(plgain_reg), Q_SHIFT) + sx16(ploff_reg);
  wire [15:0] pre_sat = sat16(pre_sum);
  wire [15:0] pre_result = pre_sat[15] ? 16'h0000 : pre_sat;

  // Differential setpoints: running sum gives the segment start
  wire [3:0] seg = lin_in_reg[14:11];
  wire [10:0] frac = lin_in_reg[10:0];
  logic signed [47:0] seg_base;
  always_comb begin
    seg_base = '0;
    for (int j = 0; j < NUM_PTS; j++) begin
      if (j < int'(seg)) begin
        seg_base = seg_base + sx16(lin_pts[j]);
      end
    end
  end
  wire signed [47:0] seg_ramp = mul_sh(sx16(lin_pts[seg]), {37'h0, frac}, SEG_SHIFT);
  wire [15:0] lin_result = sat16(sx16(lin_in_reg) + seg_base + seg_ramp);

  // Output scaling and clamp
  wire [15:0] out_scaled = sat16(mul_sh(sx16(lin_out_reg), sx16(ogain_reg), Q_SHIFT) + sx16(ooff_reg));
  wire above_hi = $signed(out_scaled) > $signed(clhi_reg);
  wire below_lo = $signed(out_scaled) < $signed(cllo_reg);
  wire [15:0] out_clamped = above_hi ? clhi_reg : (below_lo ? cllo_reg : out_scaled);

  // Pulse rate decode
  wire [1:0] rate_code = setup_reg[RATE_LSB+1:RATE_LSB];
  wire [17:0] rate_period = rate_code == 2'b11 ? PER_2K : rate_code == 2'b00 ? PER_1K :
                            rate_code == 2'b01 ? PER_500 : PER_250;
  wire [3:0] rate_res = rate_code == 2'b11 ? RES_11 : RES_12;

  // Readback
  logic [15:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      A_STATUS: rd_mux = status_reg & STATUS_MASK;
      A_PROGERR: rd_mux = progerr_reg & PROGERR_MASK;
      A_TAG1: rd_mux = tag1_reg;
      A_TAG2: rd_mux = tag2_reg;
      A_TGC0: rd_mux = tgc0_reg;
      A_TGC1: rd_mux = tgc1_reg;
      A_TGC2: rd_mux = tgc2_reg;
      A_TOC0: rd_mux = toc0_reg;
      A_TOC1: rd_mux = toc1_reg;
      A_PLGAIN: rd_mux = plgain_reg;
      A_PLOFF: rd_mux = ploff_reg;
      A_OGAIN: rd_mux = ogain_reg;
      A_OOFF: rd_mux = ooff_reg;
      A_CLHI: rd_mux = clhi_reg;
      A_CLLO: rd_mux = cllo_reg;
      A_SETUP: rd_mux = setup_reg;
      A_RAWFLD: rd_mux = raw_field_value;
      A_OUTVAL: rd_mux = out_value_reg;
      default: rd_mux = reg_addr[5:4] == A_LINPT[5:4] ? lin_pts[reg_addr[3:0]] : 16'h0000;
    endcase
  end

  // Sequencer; the output hold stalls the FIFO drain
  always_comb begin
    unique case (state_reg)
      ST_IDLE: state_next = fifo_valid ? ST_RANGE : ST_IDLE;
      ST_RANGE: state_next = ST_TEMP;
      ST_TEMP: state_next = ST_PRELIN;
      ST_PRELIN: state_next = ST_LIN;
      ST_LIN: state_next = ST_OUT;
      ST_OUT: state_next = (!out_valid_reg || out_ready) ? ST_IDLE : ST_OUT;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      raw_reg <= '0;
      temp_reg <= RST_ZERO;
      ovf_seen_reg <= 1'b0;
      field_comp_reg <= RST_ZERO;
      lin_in_reg <= RST_ZERO;
      lin_out_reg <= RST_ZERO;
      out_value_reg <= RST_ZERO;
      out_valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_IDLE && fifo_valid) begin
        {ovf_seen_reg, temp_reg, raw_reg} <= fifo_data;
      end
      if (state_reg == ST_RANGE) begin
        field_comp_reg <= temp_result;
      end
      if (state_reg == ST_TEMP) begin
        lin_in_reg <= pre_result;
      end
      if (state_reg == ST_PRELIN) begin
        lin_out_reg <= lin_result;
      end
      if (state_reg == ST_OUT && state_next == ST_IDLE) begin
        out_value_reg <= out_clamped;
        out_valid_reg <= 1'b1;
      end else if (out_ready) begin
        out_valid_reg <= 1'b0;
      end
    end
  end

  // Diagnosis flags: status sticky until reset, error flags cleared by prog_start; set wins over a clear
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      status_reg <= RST_ZERO;
      progerr_reg <= RST_ZERO;
    end else begin
      if (fsm_selftest_fail) status_reg[B_FSM_FAIL] <= 1'b1;
      if (powerup_check && mem_selftest_fail) status_reg[B_MEM_FAIL] <= 1'b1;
      if (rom_parity_fail) status_reg[B_ROM_FAIL] <= 1'b1;
      if (state_reg == ST_RANGE && ovf_seen_reg) status_reg[B_ADC_OVF] <= 1'b1;
      progerr_reg[B_PUMP_ERR] <= pump_low || (progerr_reg[B_PUMP_ERR] && !prog_start);
      progerr_reg[B_SUPPLY_ERR] <= supply_low || (progerr_reg[B_SUPPLY_ERR] && !prog_start);
      progerr_reg[B_NVM_ERR] <= nvm_prog_fail || (progerr_reg[B_NVM_ERR] && !prog_start);
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tag1_reg <= RST_ZERO;
      tag2_reg <= RST_ZERO;
      tgc0_reg <= RST_UNITY;
      tgc1_reg <= RST_ZERO;
      tgc2_reg <= RST_ZERO;
      toc0_reg <= RST_ZERO;
      toc1_reg <= RST_ZERO;
      plgain_reg <= RST_UNITY;
      ploff_reg <= RST_ZERO;
      ogain_reg <= RST_UNITY;
      ooff_reg <= RST_ZERO;
      clhi_reg <= RST_CLHI;
      cllo_reg <= RST_ZERO;
      setup_reg <= RST_SETUP;
      lock_reg <= 1'b0;
    end else if (wr_ok) begin
      unique case (reg_addr)
        A_TAG1: tag1_reg <= reg_wdata;
        A_TAG2: tag2_reg <= reg_wdata;
        A_TGC0: tgc0_reg <= reg_wdata;
        A_TGC1: tgc1_reg <= reg_wdata;
        A_TGC2: tgc2_reg <= reg_wdata;
        A_TOC0: toc0_reg <= reg_wdata;
        A_TOC1: toc1_reg <= reg_wdata;
        A_PLGAIN: plgain_reg <= reg_wdata;
        A_PLOFF: ploff_reg <= reg_wdata;
        A_OGAIN: ogain_reg <= reg_wdata;
        A_OOFF: ooff_reg <= reg_wdata;
        A_CLHI: clhi_reg <= reg_wdata;
        A_CLLO: cllo_reg <= reg_wdata;
        A_SETUP: setup_reg <= reg_wdata & setup_mask;
        default: tag1_reg <= tag1_reg;
      endcase
      if (wr_setup && reg_wdata[SETUP_LOCK]) lock_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (wr_pt) begin
      lin_pts[reg_addr[3:0]] <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= RST_ZERO;
      reg_rvalid <= 1'b0;
      pulse_period <= PER_1K;
      pulse_resolution <= RES_12;
      memory_locked <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) reg_rdata <= rd_mux;
      pulse_period <= rate_period;
      pulse_resolution <= rate_res;
      memory_locked <= lock_reg;
    end
  end

  assign out_value = out_value_reg;
  assign out_valid = out_valid_reg;

  chk_status_reserved: assert property (@(posedge sys_clk) disable iff (srst)
    reg_rvalid && $past(reg_addr) == A_STATUS |-> (reg_rdata & ~STATUS_MASK) == 16'h0000)
    else $error("status reserved bits nonzero");
  chk_fsm_fail_set: assert property (@(posedge sys_clk) disable iff (srst)
    fsm_selftest_fail |=> status_reg[B_FSM_FAIL] [*3])
    else $error("state machine fail not held");
  chk_mem_test_window: assert property (@(posedge sys_clk) disable iff (srst)
    !powerup_check && !status_reg[B_MEM_FAIL] |=> !status_reg[B_MEM_FAIL])
    else $error("memory fail set outside power-up");
  chk_rom_fail_set: assert property (@(posedge sys_clk) disable iff (srst)
    rom_parity_fail |=> status_reg[B_ROM_FAIL])
    else $error("rom parity fail not flagged");
  chk_ovf_flag_set: assert property (@(posedge sys_clk) disable iff (srst)
    state_reg == ST_RANGE && ovf_seen_reg |=> status_reg[B_ADC_OVF])
    else $error("overrange not flagged");
  chk_pump_err_set: assert property (@(posedge sys_clk) disable iff (srst)
    pump_low && prog_start |=> progerr_reg[B_PUMP_ERR])
    else $error("pump error lost on clear");
  chk_supply_err_set: assert property (@(posedge sys_clk) disable iff (srst)
    supply_low |=> progerr_reg[B_SUPPLY_ERR])
    else $error("supply error not flagged");
  chk_nvm_err_set: assert property (@(posedge sys_clk) disable iff (srst)
    nvm_prog_fail |=> progerr_reg[B_NVM_ERR])
    else $error("setup memory error not flagged");
  chk_lin_nonneg: assert property (@(posedge sys_clk) disable iff (srst)
    state_reg == ST_LIN |-> !lin_in_reg[15])
    else $error("linearizer input negative");
  chk_out_clamp: assert property (@(posedge sys_clk) disable iff (srst)
    $rose(out_valid_reg) && $signed(cllo_reg) <= $signed(clhi_reg) |->
      $signed(out_value_reg) <= $signed(clhi_reg) && $signed(out_value_reg) >= $signed(cllo_reg))
    else $error("output outside clamp levels");
  chk_lock_write: assert property (@(posedge sys_clk) disable iff (srst)
    lock_reg && reg_wr && reg_addr == A_TAG1 |=> $stable(tag1_reg) && lock_reg)
    else $error("write accepted while locked");
endmodule : hdsp_core
`default_nettype wire

// *** dv/hdsp_prog_model.sv ***
// Programmer model that drives the register port of the conditioning core.
// Assumes the same sys_clk; the error word is read back after every write.
`timescale 1ns/1ns
`default_nettype none
module hdsp_prog_model (
  input wire logic sys_clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [5:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid
);
  import hdsp_pkg::*;
  logic [15:0] last_err;
  logic last_ok;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 16'h0000;
  end
  // Released lines show the inverse, so stale values never look valid
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    last_ok = reg_rvalid;
    d = reg_rdata;
  endtask : rd
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    rd(A_PROGERR, last_err);
  endtask : wr
endmodule : hdsp_prog_model
`default_nettype wire

// *** dv/tb_top.sv ***
// Testbench for the Hall conditioning core: registers, stream, diagnosis.
// Assumes hdsp_prog_model drives the register port; temperature 0 except one test.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import hdsp_pkg::*;
  typedef struct packed {logic [2:0] code; logic [21:0] raw; logic [5:0] xa;
    logic [15:0] xd; logic [15:0] xr; logic [15:0] exp;} hdsp_row_t;
  logic sys_clk = 1'b0, srst = 1'b1, sample_valid = 1'b0, sample_overrange = 1'b0, out_ready = 1'b1;
  logic [21:0] sample_raw = 22'h000000;
  logic [15:0] sample_temp = 16'h0000;
  logic [7:0] flt = 8'h00;
  logic sample_ready, out_valid, memory_locked, reg_wr, reg_rd, reg_rvalid;
  logic [15:0] out_value, reg_wdata, reg_rdata, rv;
  logic [17:0] pulse_period;
  logic [3:0] pulse_resolution;
  logic [5:0] reg_addr;
  int mismatches = 0, tests_run = 0, cyc = 0, n;
  logic [15:0] rst_v [12] = '{16'h7fff, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h7fff,
    16'h0000, 16'h7fff, 16'h0000, 16'h7fff, 16'h0000, 16'h1000};
  logic [17:0] per_v [4] = '{PER_1K, PER_500, PER_250, PER_2K};
  // Gains of 7fff lose one count per stage, so plain rows with a positive field expect field minus 3
  hdsp_row_t rows [17] = '{
    '{3'h0, 22'h040000, A_TAG1, 16'h0000, 16'h0000, 16'h0ffd},
    '{3'h1, 22'h020000, A_TAG1, 16'h0000, 16'h0000, 16'h0ffd},
    '{3'h2, 22'h002000, A_TAG1, 16'h0000, 16'h0000, 16'h01fd},
    '{3'h3, 22'h00a000, A_TAG1, 16'h0000, 16'h0000, 16'h13fd},
    '{3'h4, 22'h002000, A_TAG1, 16'h0000, 16'h0000, 16'h07fd},
    '{3'h5, 22'h002000, A_TAG1, 16'h0000, 16'h0000, 16'h0ffd},
    '{3'h6, 22'h001000, A_TAG1, 16'h0000, 16'h0000, 16'h0ffd},
    '{3'h1, 22'h1fffff, A_TAG1, 16'h0000, 16'h0000, 16'h7ffc},
    '{3'h6, 22'h3f0000, A_TAG1, 16'h0000, 16'h0000, 16'h0000},
    '{3'h6, 22'h001000, A_OOFF, 16'h0010, 16'h0000, 16'h100d},
    '{3'h6, 22'h001000, A_TOC0, 16'h0010, 16'h0000, 16'h100d},
    '{3'h6, 22'h002000, A_CLHI, 16'h1000, 16'h7fff, 16'h1000},
    '{3'h6, 22'h3f0000, A_CLLO, 16'h0020, 16'h0000, 16'h0020},
    '{3'h6, 22'h000403, A_LINPT, 16'h0100, 16'h0000, 16'h0480},
    '{3'h6, 22'h001000, A_OGAIN, 16'h4000, 16'h7fff, 16'h07ff},
    '{3'h6, 22'h001000, A_PLGAIN, 16'h4000, 16'h7fff, 16'h07fe},
    '{3'h6, 22'h001000, A_TGC0, 16'h4000, 16'h7fff, 16'h07fe}};
  always #10 sys_clk = ~sys_clk;
  hdsp_core #(.PULSE_VARIANT(1'b1)) hdsp_core_inst (.sys_clk(sys_clk), .srst(srst),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_raw(sample_raw),
    .sample_temp(sample_temp), .sample_overrange(sample_overrange), .out_valid(out_valid),
    .out_ready(out_ready), .out_value(out_value), .pulse_period(pulse_period),
    .pulse_resolution(pulse_resolution), .memory_locked(memory_locked),
    .fsm_selftest_fail(flt[0]), .powerup_check(flt[1]), .mem_selftest_fail(flt[2]),
    .rom_parity_fail(flt[3]), .prog_start(flt[4]), .pump_low(flt[5]), .supply_low(flt[6]),
    .nvm_prog_fail(flt[7]), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  hdsp_prog_model hdsp_prog_model_inst (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task automatic chk_val(input logic [17:0] got, input logic [17:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val
  // Read answer must come exactly one cycle after the request
  task automatic chk_reg(input logic [5:0] a, input logic [15:0] exp);
    hdsp_prog_model_inst.rd(a, rv);
    chk_val({1'b0, hdsp_prog_model_inst.last_ok, rv}, {2'b01, exp});
  endtask : chk_reg
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    hdsp_prog_model_inst.wr(a, d);
  endtask : wr
  task automatic pulse(input logic [7:0] m);
    @(posedge sys_clk);
    flt <= m;
    @(posedge sys_clk);
    flt <= 8'h00;
  endtask : pulse
  task automatic send(input logic [21:0] raw, input logic ovr, output logic [15:0] res);
    int k;
    @(posedge sys_clk);
    sample_valid <= 1'b1;
    sample_raw <= raw;
    sample_overrange <= ovr;
    k = 0;
    do @(posedge sys_clk); while (sample_ready !== 1'b1 && ++k < 50);
    sample_valid <= 1'b0;
    sample_raw <= ~raw;
    sample_overrange <= ~ovr;
    do @(posedge sys_clk); while (out_valid !== 1'b1 && ++k < 100);
    res = out_value;
    if (k >= 100) mismatches++;
  endtask : send
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    chk_val(pulse_period, PER_1K);
    chk_val(pulse_resolution, RES_12);
    chk_val(memory_locked, 1'b0);
    chk_val(out_valid, 1'b0);
    foreach (rst_v[i]) chk_reg(6'(i + 4), rst_v[i]);
    $display("Test reset done");
    for (int i = 0; i < 16; i++) wr(6'(A_LINPT + i), 16'h0000);
    chk_val(hdsp_prog_model_inst.last_err, 16'h0000);
    foreach (rows[i]) begin
      wr(A_SETUP, {1'b0, rows[i].code, 12'h000});
      wr(rows[i].xa, rows[i].xd);
      send(rows[i].raw, 1'b0, rv);
      chk_val(rv, rows[i].exp);
      wr(rows[i].xa, rows[i].xr);
      $display("Test row %0d done", i);
    end
    // Temperature 0.5 in Q15 exercises the higher polynomial terms
    sample_temp <= 16'h4000;
    wr(A_TGC1, 16'h4000);
    send(22'h001000, 1'b0, rv);
    chk_val(rv, 16'h13fd);
    wr(A_TGC1, 16'h0000);
    wr(A_TGC2, 16'h4000);
    send(22'h001000, 1'b0, rv);
    chk_val(rv, 16'h11fd);
    wr(A_TGC2, 16'h0000);
    wr(A_TOC1, 16'h0020);
    send(22'h001000, 1'b0, rv);
    chk_val(rv, 16'h100d);
    wr(A_TOC1, 16'h0000);
    sample_temp <= 16'h0000;
    $display("Test temperature done");
    for (int i = 0; i < 4; i++) begin
      wr(A_SETUP, {4'h1, 2'(i), 10'h000});
      chk_val(pulse_period, per_v[i]);
      chk_val(pulse_resolution, (i == 3) ? RES_11 : RES_12);
    end
    wr(A_SETUP, 16'hfffe);
    chk_reg(A_SETUP, 16'h7ffe);
    wr(A_SETUP, 16'h1000);
    $display("Test setup done");
    pulse(8'h04);
    chk_reg(A_STATUS, 16'h0000);
    pulse(8'h0f);
    chk_reg(A_STATUS, 16'h0038);
    send(22'h001000, 1'b1, rv);
    wr(A_STATUS, 16'hffff);
    chk_reg(A_STATUS, 16'h003c);
    pulse(8'h20);
    chk_reg(A_PROGERR, 16'h0400);
    pulse(8'hc0);
    chk_reg(A_PROGERR, 16'h0700);
    pulse(8'h10);
    chk_reg(A_PROGERR, 16'h0000);
    wr(6'h3f, 16'hffff);
    chk_reg(6'h3f, 16'h0000);
    $display("Test diagnosis done");
    // One result held at the output and one stalled in the pipeline beside the 32 held
    @(posedge sys_clk);
    out_ready <= 1'b0;
    sample_valid <= 1'b1;
    n = 0;
    repeat (60) begin
      @(posedge sys_clk);
      if (sample_ready === 1'b1) n++;
    end
    chk_val(18'(n), 18'd34);
    sample_valid <= 1'b0;
    out_ready <= 1'b1;
    n = 0;
    repeat (300) begin
      @(posedge sys_clk);
      if (out_valid === 1'b1) n++;
    end
    chk_val(18'(n), 18'd34);
    $display("Test buffer done");
    wr(A_TAG1, 16'h5a5a);
    chk_reg(A_TAG1, 16'h5a5a);
    wr(A_SETUP, 16'h1001);
    chk_val(memory_locked, 1'b1);
    wr(A_TAG1, 16'ha5a5);
    chk_reg(A_TAG1, 16'h5a5a);
    $display("Test lock done");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
